// ---- common/sac_consts.svh ----
// register map, field positions, reset values and timing counts
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
`define SAC_A_CTRL     8'h00
`define SAC_A_CHEN     8'h04
`define SAC_A_LIMIT    8'h08
`define SAC_A_ISTAT    8'h0C
`define SAC_A_IMASK    8'h10
`define SAC_A_APER     8'h14
`define SAC_A_ROUTE    8'h18
`define SAC_A_STATUS   8'h1C
`define SAC_A_LAST     8'h1C
`define SAC_G_STIME    2'b01
`define SAC_G_RES      2'b10
`define SAC_F_EN       0
`define SAC_F_FW       1
`define SAC_F_REF      2
`define SAC_F_EXP      4
`define SAC_F_TEMP     5
`define SAC_F_FWCH     8
`define SAC_F_TEMPCH   12
`define SAC_F_HI       16
`define SAC_I_OOR      0
`define SAC_I_SCAN     1
`define SAC_CTRL_RST   16'h0000
`define SAC_CHEN_RST   16'h00FF
`define SAC_LIMIT_RST  32'h0FFF_0000
`define SAC_STIME_RST  8'h03
`define SAC_APER_RST   8'h00
`define SAC_ROUTE_RST  32'h0000_0000
`define SAC_RESP_OK    2'b00
`define SAC_RESP_ERR   2'b10
`define SAC_CLK_MHZ    125
`define SAC_CONV_MHZ   18
`define SAC_DIV        ((`SAC_CLK_MHZ + `SAC_CONV_MHZ - 1) / `SAC_CONV_MHZ)
`define SAC_CONV_CYC   18
`endif

// ---- common/sac_pkg.sv ----
// types shared by the sequencer
package sac_pkg;
  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_sample = 3'b010,
    st_conv   = 3'b100
  } sac_state_e;
  typedef enum logic [1:0] {
    ref_vdd      = 2'b00,
    ref_vdd_half = 2'b01,
    ref_internal = 2'b10,
    ref_external = 2'b11
  } sac_ref_e;
endpackage

// ---- hw/sac_seq.sv ----
// sar converter channel sequencer with axi4-lite registers
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sac_consts.svh"

// How it works
// - twelve-bit results, one per conversion, near one million per second
// - converter clock at most 18 MHz; a conversion spans 18 ticks
// - the scan takes eight channels normally, sixteen when the expansion bit is set
// - when started, enabled channels convert in turn and the scan repeats
// - the next channel starts sampling right as a conversion ends
// - control bit chooses automatic stepping or a firmware-chosen channel
// - every channel has its own result word
// - every channel has its own sample time, used whenever it is converted
// - low and high limits; a result outside them flags out-of-range
// - the out-of-range flag is set in the cycle after the conversion's last cycle
// - a programmable aperture lengthens every sample phase
// - reference select drives one of four sources to the converter
// - a chosen channel can be routed to the temperature sensor instead
// - a low-power mode input stops the converter clock and the sequencer
// - sequencer can close the opamp routing switches, as firmware can
module sac_seq (
  input  wire logic        sys_clk_i,        // system clock 125 MHz
  input  wire logic        arst_n_i,         // async reset, active low
  input  wire logic [7:0]  s_axi_awaddr_i,   // write address
  input  wire logic        s_axi_awvalid_i,  // write address valid
  output logic             s_axi_awready_o,  // write address ready
  input  wire logic [31:0] s_axi_wdata_i,    // write data
  input  wire logic [3:0]  s_axi_wstrb_i,    // write byte strobes
  input  wire logic        s_axi_wvalid_i,   // write data valid
  output logic             s_axi_wready_o,   // write data ready
  output logic [1:0]       s_axi_bresp_o,    // write response
  output logic             s_axi_bvalid_o,   // write response valid
  input  wire logic        s_axi_bready_i,   // write response ready
  input  wire logic [7:0]  s_axi_araddr_i,   // read address
  input  wire logic        s_axi_arvalid_i,  // read address valid
  output logic             s_axi_arready_o,  // read address ready
  output logic [31:0]      s_axi_rdata_o,    // read data
  output logic [1:0]       s_axi_rresp_o,    // read response
  output logic             s_axi_rvalid_o,   // read data valid
  input  wire logic        s_axi_rready_i,   // read data ready
  input  wire logic        lp_mode_i,        // deep sleep or hibernate
  input  wire logic [11:0] adc_data_i,       // converter core result
  output logic             adc_clk_o,        // converter clock
  output logic [3:0]       adc_ch_o,         // active channel
  output logic             adc_temp_o,       // temperature sensor selected
  output logic [1:0]       adc_ref_o,        // reference select
  output logic             adc_sample_o,     // sample-and-hold tracking
  output logic             adc_conv_o,       // conversion running
  output logic             opamp_first_sw_o, // first opamp switch
  output logic             opamp_second_sw_o,// second opamp switch
  output logic             irq_o             // interrupt, active high
);

  localparam logic [2:0] DIV_LAST = 3'(`SAC_DIV - 1);
  localparam logic [2:0] DIV_HALF = 3'(`SAC_DIV / 2);
  localparam logic [8:0] CONV_LAST = 9'(`SAC_CONV_CYC - 1);

  logic [1:0]          lp_sync;
  logic                lp;
  logic [2:0]          div_cnt;
  logic                tick;
  logic                clk_q;
  sac_pkg::sac_state_e state;
  logic [3:0]          cur_ch;
  logic [8:0]          phase;
  logic [15:0]         ctrl;
  logic [15:0]         chen;
  logic [31:0]         limit;
  logic [1:0]          istat;
  logic [1:0]          imask;
  logic [7:0]          aper;
  logic [31:0]         route;
  logic [7:0]          stime [16];
  logic [12:0]         res   [16];
  logic [15:0]         eff_mask;
  logic                run;
  logic [3:0]          pick;
  logic                done_ev;
  logic                oor;
  logic                wrap;
  logic                aw_hold;
  logic                w_hold;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                wr_go;
  logic [31:0]         wmask;
  logic [31:0]         rd_val;
  logic                sw_first;
  logic                sw_second;
  logic                temp_q;

  // next enabled channel after cur, wrapping; cur itself if it is the only one
  function automatic logic [3:0] sac_next(input logic [3:0]  cur,
                                          input logic [15:0] m);
    logic [3:0] c;
    logic [3:0] r;
    logic       f;
    r = cur;
    f = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      c = cur + 4'(i);
      if (!f && m[c]) begin
        r = c;
        f = 1'b1;
      end
    end
    return r;
  endfunction

  // sample phase length in converter ticks, minus one
  function automatic logic [8:0] sac_slen(input logic [7:0] st,
                                          input logic [7:0] ap);
    return {1'b0, st} + {1'b0, ap};
  endfunction

  // true for any implemented word address
  function automatic logic sac_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && ((a <= `SAC_A_LAST) ||
           (a[7:6] == `SAC_G_STIME) || (a[7:6] == `SAC_G_RES));
  endfunction

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] sac_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [31:0] m);
    return (old & ~m) | (wd & m);
  endfunction

  // the power-mode pin is asynchronous: two flops before use
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lp_sync <= 2'b00;
    end else begin
      lp_sync <= {lp_sync[0], lp_mode_i};
    end
  end
  assign lp = lp_sync[1];

  // converter clock: divide to the highest rate not above 18 MHz
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= 3'h0;
      clk_q   <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == DIV_LAST) ? 3'h0 : div_cnt + 3'h1;
      clk_q   <= ~lp && (div_cnt < DIV_HALF);
    end
  end
  assign tick      = (div_cnt == DIV_LAST);
  assign adc_clk_o = clk_q;

  // channels beyond eight only count when expansion is on
  assign eff_mask = chen & (ctrl[`SAC_F_EXP] ? 16'hFFFF : 16'h00FF);
  // low-power mode holds the sequencer idle; no high-speed clock there
  assign run = ctrl[`SAC_F_EN] && !lp &&
               (ctrl[`SAC_F_FW] || (eff_mask != 16'h0000));
  // firmware mode pins the channel, otherwise the scan walks the mask
  assign pick = ctrl[`SAC_F_FW] ? ctrl[`SAC_F_FWCH +: 4] :
                sac_next((state == sac_pkg::st_idle) ? 4'hF : cur_ch,
                         eff_mask);
  assign done_ev = (state == sac_pkg::st_conv) && tick && (phase == 9'h000);
  assign wrap = !ctrl[`SAC_F_FW] && (pick <= cur_ch);
  // window check against the limits on the finished result
  assign oor = (adc_data_i < limit[11:0]) ||
               (adc_data_i > limit[`SAC_F_HI +: 12]);

  // sequencer: sample, convert, then straight into the next sample
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state  <= sac_pkg::st_idle;
      cur_ch <= 4'h0;
      phase  <= 9'h000;
    end else if (!run) begin
      state <= sac_pkg::st_idle;
      phase <= 9'h000;
    end else if (tick) begin
      case (state)
        sac_pkg::st_idle: begin
          state  <= sac_pkg::st_sample;
          cur_ch <= pick;
          phase  <= sac_slen(stime[pick], aper);
        end
        sac_pkg::st_sample: begin
          if (phase == 9'h000) begin
            state <= sac_pkg::st_conv;
            phase <= CONV_LAST;
          end else begin
            phase <= phase - 9'h001;
          end
        end
        sac_pkg::st_conv: begin
          if (phase == 9'h000) begin
            // no idle tick between channels keeps the aggregate rate
            state  <= sac_pkg::st_sample;
            cur_ch <= pick;
            phase  <= sac_slen(stime[pick], aper);
          end else begin
            phase <= phase - 9'h001;
          end
        end
        default: begin
          state <= sac_pkg::st_idle;
        end
      endcase
    end
  end

  // per-channel sample time and result storage
  generate
    for (genvar g = 0; g < 16; g++) begin : g_ch
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          stime[g] <= `SAC_STIME_RST;
        end else if (wr_go && aw_addr[7:6] == `SAC_G_STIME &&
                     aw_addr[5:2] == 4'(g) && w_strb[0]) begin
          stime[g] <= w_data[7:0];
        end
      end
      // bit 12 marks a result that has been written at least once
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          res[g] <= 13'h0000;
        end else if (done_ev && cur_ch == 4'(g)) begin
          res[g] <= {1'b1, adc_data_i};
        end
      end
    end
  endgenerate

  // interrupt status: sticky, write one to clear, a new event wins
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      istat <= 2'b00;
    end else begin
      istat <= (istat & ~((wr_go && aw_addr == `SAC_A_ISTAT) ?
                          (w_data[1:0] & wmask[1:0]) : 2'b00)) |
               {done_ev && wrap,
                done_ev && oor};
    end
  end
  assign irq_o = |(istat & imask);

  // software control registers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl  <= `SAC_CTRL_RST;
      chen  <= `SAC_CHEN_RST;
      limit <= `SAC_LIMIT_RST;
      imask <= 2'b00;
      aper  <= `SAC_APER_RST;
      route <= `SAC_ROUTE_RST;
    end else if (wr_go) begin
      case (aw_addr)
        `SAC_A_CTRL:  ctrl  <= 16'(sac_merge({16'h0000, ctrl}, w_data, wmask));
        `SAC_A_CHEN:  chen  <= 16'(sac_merge({16'h0000, chen}, w_data, wmask));
        `SAC_A_LIMIT: limit <= sac_merge(limit, w_data, wmask) &
                               32'h0FFF_0FFF;
        `SAC_A_IMASK: imask <= w_strb[0] ? w_data[1:0] : imask;
        `SAC_A_APER:  aper  <= w_strb[0] ? w_data[7:0] : aper;
        `SAC_A_ROUTE: route <= sac_merge(route, w_data, wmask);
        default:      ;
      endcase
    end
  end

  // axi write: address and data are caught in either order
  assign s_axi_awready_o = !aw_hold;
  assign s_axi_wready_o  = !w_hold;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid_o;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                  {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid_i && !aw_hold) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && !w_hold) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (wr_go) begin
      w_hold <= 1'b0;
    end
  end

  // write response; read-only words accept and drop the data
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `SAC_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= sac_mapped(aw_addr) ? `SAC_RESP_OK : `SAC_RESP_ERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr_i)
      `SAC_A_CTRL:   rd_val = {16'h0000, ctrl};
      `SAC_A_CHEN:   rd_val = {16'h0000, chen};
      `SAC_A_LIMIT:  rd_val = limit;
      `SAC_A_ISTAT:  rd_val = {30'h0000_0000, istat};
      `SAC_A_IMASK:  rd_val = {30'h0000_0000, imask};
      `SAC_A_APER:   rd_val = {24'h00_0000, aper};
      `SAC_A_ROUTE:  rd_val = route;
      `SAC_A_STATUS: rd_val = {23'h00_0000, lp, state, cur_ch, run};
      default: begin
        if (s_axi_araddr_i[7:6] == `SAC_G_STIME) begin
          rd_val = {24'h00_0000, stime[s_axi_araddr_i[5:2]]};
        end else if (s_axi_araddr_i[7:6] == `SAC_G_RES) begin
          rd_val = {19'h0_0000, res[s_axi_araddr_i[5:2]]};
        end
      end
    endcase
  end

  // read channel: one word in flight, answered the cycle after arrival
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `SAC_RESP_OK;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_val;
      s_axi_rresp_o  <= sac_mapped(s_axi_araddr_i) ? `SAC_RESP_OK :
                                                     `SAC_RESP_ERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // switches: firmware bits or the active channel's map bit while sampling or converting
  // low channels steer the first opamp, high channels the second
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_first  <= 1'b0;
      sw_second <= 1'b0;
      temp_q    <= 1'b0;
    end else begin
      sw_first  <= route[0] || (state != sac_pkg::st_idle &&
                   route[16 + cur_ch] && !cur_ch[3]);
      sw_second <= route[1] || (state != sac_pkg::st_idle &&
                   route[16 + cur_ch] && cur_ch[3]);
      temp_q    <= ctrl[`SAC_F_TEMP] &&
                   (cur_ch == ctrl[`SAC_F_TEMPCH +: 4]);
    end
  end

  // converter core controls; state is one-hot so its bits are flops
  assign adc_sample_o      = state[1];
  assign adc_conv_o        = state[2];
  assign adc_ch_o          = cur_ch;
  assign adc_ref_o         = ctrl[`SAC_F_REF +: 2];
  assign adc_temp_o        = temp_q;
  assign opamp_first_sw_o  = sw_first;
  assign opamp_second_sw_o = sw_second;

endmodule // sac_seq
`default_nettype wire

// ---- tb/sac_seq_chk.sv ----
// concurrent checks on the sequencer's ports
`timescale 1ns/100ps
`default_nettype none
module sac_seq_chk (
  input wire logic        sys_clk_i,       // system clock
  input wire logic        arst_n_i,        // async reset, active low
  input wire logic        s_axi_awvalid_i, // write address valid
  input wire logic        s_axi_awready_o, // write address ready
  input wire logic        s_axi_wvalid_i,  // write data valid
  input wire logic        s_axi_wready_o,  // write data ready
  input wire logic [1:0]  s_axi_bresp_o,   // write response
  input wire logic        s_axi_bvalid_o,  // write response valid
  input wire logic        s_axi_bready_i,  // write response ready
  input wire logic [31:0] s_axi_rdata_o,   // read data
  input wire logic        s_axi_rvalid_o,  // read data valid
  input wire logic        s_axi_rready_i,  // read data ready
  input wire logic        lp_mode_i,       // low-power request
  input wire logic        adc_clk_o,       // converter clock
  input wire logic [3:0]  adc_ch_o,        // active channel
  input wire logic        adc_sample_o,    // sample phase
  input wire logic        adc_conv_o       // conversion phase
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0] conv_cnt;
  // counts system clocks of the running conversion
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) conv_cnt <= 8'h00;
    else if (adc_conv_o) conv_cnt <= conv_cnt + 8'h01;
    else conv_cnt <= 8'h00;
  end
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rvalid dropped");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write not answered");
  // lp holds the converter clock low, so shape checks stand down while it is asked
  clk_shape_a: assert property (
    disable iff (!arst_n_i || lp_mode_i) $rose(adc_clk_o) |->
    adc_clk_o[*3] ##1 !adc_clk_o[*4] ##1 adc_clk_o) else $error("adc clock");
  conv_len_a: assert property (
    disable iff (!arst_n_i || lp_mode_i)
    $fell(adc_conv_o) |-> conv_cnt == 8'h7E) else $error("conversion length");
  no_gap_a: assert property (
    disable iff (!arst_n_i || lp_mode_i) ($fell(adc_conv_o) |-> adc_sample_o)
    and ($fell(adc_sample_o) |-> adc_conv_o)) else $error("dead cycle");
  ch_hold_a: assert property (
    adc_conv_o && $past(adc_conv_o) |-> $stable(adc_ch_o))
    else $error("channel moved in conversion");
  lp_stop_a: assert property (
    lp_mode_i[*6] |-> !adc_clk_o && !adc_sample_o && !adc_conv_o)
    else $error("converter runs in low power");
  cover property ($fell(adc_conv_o));
  cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
  cover property (lp_mode_i && !adc_clk_o);
endmodule // sac_seq_chk
bind sac_seq sac_seq_chk chk_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .lp_mode_i(lp_mode_i), .adc_clk_o(adc_clk_o), .adc_ch_o(adc_ch_o),
  .adc_sample_o(adc_sample_o), .adc_conv_o(adc_conv_o));
`default_nettype wire

// ---- tb/sac_core_model.sv ----
// converter core stand-in returning a channel-dependent result
`timescale 1ns/100ps
`default_nettype none
module sac_core_model (
  input  wire logic        sys_clk_i,  // system clock
  input  wire logic        adc_conv_i, // conversion running
  input  wire logic [3:0]  adc_ch_i,   // active channel
  input  wire logic [11:0] base_i,     // result offset
  output logic      [11:0] adc_data_o  // result word
);
  logic [11:0] last = 12'h000;
  // valid only while converting; otherwise it flips every cycle, so a
  // capture at the wrong moment shows up as a wrong result
  always_comb begin
    adc_data_o = adc_conv_i ? base_i + {adc_ch_i, 8'h00} : ~last;
  end
  always_ff @(posedge sys_clk_i) last <= adc_data_o;
endmodule // sac_core_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the sar channel sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sac_consts.svh"
module tb;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, lp;
  logic        awready, wready, bvalid, arready, rvalid, aclk, temp, smp;
  logic        conv, sw1, sw2, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, cfg, lfsr_st;
  logic [11:0] adc_data, base;
  logic [3:0]  adc_ch;
  logic [1:0]  bresp, rresp, adc_ref;
  logic [9:0]  scnt = 10'h000;
  logic [33:0] q_r[$];
  logic [31:0] q_m[$];
  logic [1:0]  q_b[$];
  logic [16:0] q_c[$];
  logic [16:0] ph;
  int          miscompares, tests_run, cyc;
  sac_seq dut_u (.sys_clk_i(clk), .arst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .lp_mode_i(lp), .adc_data_i(adc_data),
    .adc_clk_o(aclk), .adc_ch_o(adc_ch), .adc_temp_o(temp),
    .adc_ref_o(adc_ref), .adc_sample_o(smp), .adc_conv_o(conv),
    .opamp_first_sw_o(sw1), .opamp_second_sw_o(sw2), .irq_o(irq));
  // what a finished sample phase is compared on
  assign ph = {sw2, sw1, temp, adc_ch, scnt};
  sac_core_model core_u (.sys_clk_i(clk), .adc_conv_i(conv),
    .adc_ch_i(adc_ch), .base_i(base), .adc_data_o(adc_data));
  always #4 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [33:0] s, e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one write; each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic a_t, w_t;
    @(posedge clk);
    q_b.push_back(r);
    a_t = 1'b0;
    w_t = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      a_t = a_t | awready;
      w_t = w_t | wready;
      if (a_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!(a_t && w_t));
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r,
                    input logic [31:0] d, m);
    @(posedge clk);
    q_r.push_back({r, d & m});
    q_m.push_back(m);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask
  // watcher: each answer or finished sample phase takes the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rvalid && rready && q_r.size() > 0)
      chk("rd", {rresp, rdata & q_m.pop_front()}, q_r.pop_front());
    if (bvalid && bready && q_b.size() > 0)
      chk("bresp", 34'(bresp), 34'(q_b.pop_front()));
    if (smp) scnt <= scnt + 10'h001;
    else begin
      if (scnt != 10'h000 && q_c.size() > 0)
        chk("phase", 34'(ph), 34'(q_c.pop_front()));
      scnt <= 10'h000;
    end
    // the limit is the last thing the watcher does in a cycle
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, lp} = 6'h00;
    {awaddr, araddr, wdata, base} = 60'h0;
    lfsr_st = 32'hfafe_eeef;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(`SAC_A_CTRL, `SAC_RESP_OK, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`SAC_A_CHEN, `SAC_RESP_OK, 32'h0000_00FF, 32'hFFFF_FFFF);
    rd(`SAC_A_LIMIT, `SAC_RESP_OK, `SAC_LIMIT_RST, 32'hFFFF_FFFF);
    rd(8'h40, `SAC_RESP_OK, 32'h0000_0003, 32'hFFFF_FFFF);
    rd(`SAC_A_APER, `SAC_RESP_OK, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`SAC_A_ROUTE, `SAC_RESP_OK, `SAC_ROUTE_RST, 32'hFFFF_FFFF);
    rd(8'h20, `SAC_RESP_ERR, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(8'h20, 32'h0000_0001, `SAC_RESP_ERR);
    for (int r = 0; r < 4; r++) begin
      wr(`SAC_A_CTRL, 32'(r) << 2, `SAC_RESP_OK);
      repeat (2) @(posedge clk);
      chk("ref", 34'(adc_ref), 34'(r));
    end
    lfsr_st = lfsr(lfsr_st);
    base <= {4'h0, lfsr_st[7:0]};
    cfg = 32'h0000_2021 | {28'h000_0000, lfsr_st[9:8], 2'b00};
    wr(`SAC_A_CHEN, 32'h0000_0005, `SAC_RESP_OK);
    wr(`SAC_A_LIMIT, 32'h0800_0100, `SAC_RESP_OK);
    wr(8'h48, 32'h0000_0005, `SAC_RESP_OK);
    wr(`SAC_A_APER, 32'h0000_0001, `SAC_RESP_OK);
    wr(`SAC_A_ROUTE, 32'h0004_0000, `SAC_RESP_OK);
    wr(`SAC_A_IMASK, 32'h0000_0000, `SAC_RESP_OK);
    // ch0 runs 5 ticks of sampling, ch2 runs 7 ticks with temp and switch
    repeat (2) q_c.push_back(17'h0_0023);
    repeat (2) q_c.push_back(17'h0_C831);
    q_c = {q_c[0], q_c[2], q_c[1], q_c[3]};
    wr(`SAC_A_CTRL, cfg, `SAC_RESP_OK);
    repeat (800) @(posedge clk);
    chk("irq masked", 34'(irq), 34'h0);
    rd(`SAC_A_ISTAT, `SAC_RESP_OK, 32'h0000_0001, 32'h0000_0001);
    wr(`SAC_A_IMASK, 32'h0000_0001, `SAC_RESP_OK);
    repeat (2) @(posedge clk);
    chk("irq set", 34'(irq), 34'h1);
    rd(8'h80, `SAC_RESP_OK, 32'h0000_1000 | base, 32'hFFFF_FFFF);
    rd(8'h84, `SAC_RESP_OK, 32'h0000_0000, 32'h0000_1000);
    rd(8'h88, `SAC_RESP_OK, 32'h0000_1200 + base, 32'hFFFF_FFFF);
    wr(`SAC_A_CTRL, cfg | 32'h0000_0202, `SAC_RESP_OK);
    repeat (400) @(posedge clk);
    wr(`SAC_A_ISTAT, 32'h0000_0001, `SAC_RESP_OK);
    repeat (2) @(posedge clk);
    chk("irq clear", 34'(irq), 34'h0);
    repeat (2) q_c.push_back(17'h0_C831);
    repeat (400) @(posedge clk);
    // expanded scan of channel 9 alone: the second opamp switch follows it
    wr(`SAC_A_CHEN, 32'h0000_0200, `SAC_RESP_OK);
    wr(`SAC_A_ROUTE, 32'h0200_0000, `SAC_RESP_OK);
    wr(`SAC_A_CTRL, cfg | 32'h0000_0010, `SAC_RESP_OK);
    // let the channel 2 phase drain before noting channel 9 phases
    repeat (180) @(posedge clk);
    repeat (2) q_c.push_back(17'h1_2423);
    repeat (400) @(posedge clk);
    lp <= 1'b1;
    repeat (20) @(posedge clk);
    chk("lp stop", 34'({aclk, smp, conv}), 34'h0);
    finish_test();
  end
endmodule // tb
`default_nettype wire
